/* rtl/opt_slot.sv */
/*
 * One timer slot: holds base, mask, invert flag and a millisecond
 * down-count, and reports the output lines it owns.
 * Assumes a one-cycle millisecond tick from the bank on the same clock.
 */
`timescale 1ns/1ps
`include "opt_params.svh"

module opt_slot
	import opt_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Control from the bank
	input  wire logic       load,
	input  wire opt_base_t  base_in,
	input  wire opt_mask_t  mask_in,
	input  wire logic       inv_in,
	input  wire opt_dur_t   dur_in,
	input  wire logic       tick,
	// Slot state
	output opt_lines_t      sel_lines,
	output logic            inv,
	output logic            active,
	output logic            expire
);

	opt_base_t base_reg,   base_next;
	opt_mask_t mask_reg,   mask_next;
	logic      inv_reg,    inv_next;
	opt_dur_t  cnt_reg,    cnt_next;
	logic      active_reg, active_next;
	logic [`OPT_NUM_LINES+`OPT_MASK_W-2:0] wide;

	// Mask bit n lands on line base+n; bits past the last line drop off
	assign wide      = {{(`OPT_NUM_LINES-1){1'b0}}, mask_reg} << base_reg;
	assign sel_lines = wide[`OPT_NUM_LINES-1:0];
	assign inv       = inv_reg;
	assign active    = active_reg;
	assign expire    = active_reg && (cnt_reg == '0);

	always_comb begin
		base_next   = base_reg;
		mask_next   = mask_reg;
		inv_next    = inv_reg;
		cnt_next    = cnt_reg;
		active_next = active_reg;
		if (load) begin
			// A running slot is simply overwritten and restarts
			base_next   = base_in;
			mask_next   = mask_in;
			inv_next    = inv_in;
			cnt_next    = dur_in;
			active_next = 1'b1;
		end else if (expire) begin
			active_next = 1'b0;
		end else if (active_reg && tick) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_reg   <= '0;
			mask_reg   <= '0;
			inv_reg    <= 1'b0;
			cnt_reg    <= '0;
			active_reg <= 1'b0;
		end else begin
			base_reg   <= base_next;
			mask_reg   <= mask_next;
			inv_reg    <= inv_next;
			cnt_reg    <= cnt_next;
			active_reg <= active_next;
		end
	end

endmodule // opt_slot

/* rtl/opt_timer_bank.sv */
/*
 * Bank of sixty-four one-shot output timers behind an APB slave,
 * driving 32 output lines.
 * Assumes an APB3 master on pclk and that the output pins are sampled
 * by logic elsewhere; no other clock domain.
 */
// Local design decisions: the APB slave port and the register offsets.
//Behaviour
//- There are sixty-four independent slots chosen by an index 0 to 63.
//- Any slot may drive any output lines, with no fixed slot-to-line tie.
//- Each request carries a base output index from 0 to 31.
//- A sixteen-bit mask picks line base+n for each set bit n.
//- Mask bit zero is the base line and higher bits go upward.
//- Lines outside the mask stay under ordinary control during a run.
//- The slot runs for the requested number of milliseconds, then releases.
//- Normally lines go on at start and off at expiry; inverted the reverse.
`timescale 1ns/1ps
`include "opt_params.svh"

module opt_timer_bank
	import opt_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `OPT_TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`OPT_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Output lines
	output opt_lines_t                   out_lines
);

	localparam opt_tick_t TICK_LAST = opt_tick_t'(TICK_CYCLES - 1);

	// Bus state
	logic        pready_reg,  pready_next;
	logic        pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg,  prdata_next;

	// Command staging
	opt_slot_t   slot_reg,  slot_next;
	opt_base_t   base_reg,  base_next;
	logic        inv_reg,   inv_next;
	opt_mask_t   mask_reg,  mask_next;
	opt_dur_t    dur_reg,   dur_next;
	logic        go_reg,    go_next;

	// Output state
	opt_lines_t  latch_reg, latch_next;
	opt_lines_t  out_reg,   out_next;

	// Millisecond tick
	opt_tick_t   tcnt_reg,  tcnt_next;
	logic        tick_reg,  tick_next;

	// Per-slot signals
	opt_lines_t               sel   [`OPT_NUM_SLOTS];
	logic [`OPT_NUM_SLOTS-1:0] sinv;
	logic [`OPT_NUM_SLOTS-1:0] sact;
	logic [`OPT_NUM_SLOTS-1:0] sexp;

	logic access;
	logic wr_en;
	logic addr_ok;

	assign access  = psel && penable;
	// The write lands on the edge where the master sees pready high
	assign wr_en   = access && pwrite && pready_reg;

	assign prdata    = prdata_reg;
	assign pready    = pready_reg;
	assign pslverr   = pslverr_reg;
	assign out_lines = out_reg;

	genvar gi;
	generate
		for (gi = 0; gi < `OPT_NUM_SLOTS; gi++) begin : g_slot
			opt_slot opt_slot_inst (
				.pclk      (pclk),
				.presetn   (presetn),
				.load      (go_reg && (slot_reg == opt_slot_t'(gi))),
				.base_in   (base_reg),
				.mask_in   (mask_reg),
				.inv_in    (inv_reg),
				.dur_in    (dur_reg),
				.tick      (tick_reg),
				.sel_lines (sel[gi]),
				.inv       (sinv[gi]),
				.active    (sact[gi]),
				.expire    (sexp[gi])
			);
		end
	endgenerate

	// APB decode and read data
	always_comb begin
		case (paddr)
			`OPT_ADDR_CMD, `OPT_ADDR_MASK, `OPT_ADDR_DUR, `OPT_ADDR_GO,
			`OPT_ADDR_LATCH, `OPT_ADDR_LINES, `OPT_ADDR_ACT_LO,
			`OPT_ADDR_ACT_HI: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	always_comb begin
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		prdata_next  = prdata_reg;
		// One wait state: pready rises in the second access cycle
		if (access && !pready_reg) begin
			pready_next  = 1'b1;
			pslverr_next = !addr_ok;
			prdata_next  = '0;
			if (!pwrite) begin
				case (paddr)
					`OPT_ADDR_CMD: begin
						prdata_next[`OPT_CMD_SLOT_LSB +: `OPT_SLOT_W] = slot_reg;
						prdata_next[`OPT_CMD_BASE_LSB +: `OPT_BASE_W] = base_reg;
						prdata_next[`OPT_CMD_INV_BIT] = inv_reg;
					end
					`OPT_ADDR_MASK:   prdata_next[`OPT_MASK_W-1:0] = mask_reg;
					`OPT_ADDR_DUR:    prdata_next[`OPT_DUR_W-1:0] = dur_reg;
					`OPT_ADDR_LATCH:  prdata_next = latch_reg;
					`OPT_ADDR_LINES:  prdata_next = out_reg;
					`OPT_ADDR_ACT_LO: prdata_next = sact[31:0];
					`OPT_ADDR_ACT_HI: prdata_next = sact[63:32];
					default:          prdata_next = '0;
				endcase
			end
		end
	end

	// Command staging; a GO write launches the staged request next cycle
	always_comb begin
		slot_next = slot_reg;
		base_next = base_reg;
		inv_next  = inv_reg;
		mask_next = mask_reg;
		dur_next  = dur_reg;
		go_next   = 1'b0;
		if (wr_en) begin
			case (paddr)
				`OPT_ADDR_CMD: begin
					slot_next = pwdata[`OPT_CMD_SLOT_LSB +: `OPT_SLOT_W];
					base_next = pwdata[`OPT_CMD_BASE_LSB +: `OPT_BASE_W];
					inv_next  = pwdata[`OPT_CMD_INV_BIT];
				end
				`OPT_ADDR_MASK: mask_next = pwdata[`OPT_MASK_W-1:0];
				`OPT_ADDR_DUR:  dur_next  = pwdata[`OPT_DUR_W-1:0];
				`OPT_ADDR_GO:   go_next   = pwdata[`OPT_GO_BIT];
				default: ;
			endcase
		end
	end

	// Millisecond tick shared by all slots
	always_comb begin
		tick_next = 1'b0;
		tcnt_next = tcnt_reg + 1'b1;
		if (tcnt_reg == TICK_LAST) begin
			tcnt_next = '0;
			tick_next = 1'b1;
		end
	end

	// Output latch and overlay. Expiry is applied after a software write,
	// so a slot ending in the same cycle is never lost.
	always_comb begin
		latch_next = latch_reg;
		if (wr_en && paddr == `OPT_ADDR_LATCH) begin
			latch_next = pwdata;
		end
		for (int i = 0; i < `OPT_NUM_SLOTS; i++) begin
			if (sexp[i]) begin
				if (sinv[i]) begin
					latch_next = latch_next | sel[i];
				end else begin
					latch_next = latch_next & ~sel[i];
				end
			end
		end
		// Only masked lines of running slots are overridden
		out_next = latch_next;
		for (int i = 0; i < `OPT_NUM_SLOTS; i++) begin
			if (sact[i] && !sexp[i]) begin
				if (sinv[i]) begin
					out_next = out_next & ~sel[i];
				end else begin
					out_next = out_next | sel[i];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
			slot_reg    <= '0;
			base_reg    <= '0;
			inv_reg     <= 1'b0;
			mask_reg    <= '0;
			dur_reg     <= '0;
			go_reg      <= 1'b0;
			tcnt_reg    <= '0;
			tick_reg    <= 1'b0;
			latch_reg   <= `OPT_LATCH_RST;
			out_reg     <= `OPT_LATCH_RST;
		end else begin
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
			slot_reg    <= slot_next;
			base_reg    <= base_next;
			inv_reg     <= inv_next;
			mask_reg    <= mask_next;
			dur_reg     <= dur_next;
			go_reg      <= go_next;
			tcnt_reg    <= tcnt_next;
			tick_reg    <= tick_next;
			latch_reg   <= latch_next;
			out_reg     <= out_next;
		end
	end

endmodule // opt_timer_bank

/* shared/opt_params.svh */
/*
 * Constants of the output pulse timer bank: register offsets, field
 * positions, widths, reset values and the millisecond tick timing.
 * Assumes a 40 MHz APB clock and 32 physical output lines.
 */
`ifndef OPT_PARAMS_SVH
`define OPT_PARAMS_SVH

`define OPT_NUM_SLOTS      64
`define OPT_SLOT_W         6
`define OPT_NUM_LINES      32
`define OPT_BASE_W         5
`define OPT_MASK_W         16
`define OPT_DUR_W          16
`define OPT_ADDR_W         8

// Register byte offsets
`define OPT_ADDR_CMD       8'h00
`define OPT_ADDR_MASK      8'h04
`define OPT_ADDR_DUR       8'h08
`define OPT_ADDR_GO        8'h0c
`define OPT_ADDR_LATCH     8'h10
`define OPT_ADDR_LINES     8'h14
`define OPT_ADDR_ACT_LO    8'h18
`define OPT_ADDR_ACT_HI    8'h1c

// Command and GO register fields
`define OPT_CMD_SLOT_LSB   0
`define OPT_CMD_BASE_LSB   8
`define OPT_CMD_INV_BIT    16
`define OPT_GO_BIT         0

// Reset values
`define OPT_LATCH_RST      32'h0000_0000

// Millisecond tick: time in ns and cycles derived from the clock period
`define OPT_CLK_PERIOD_NS  25
`define OPT_MS_NS          1000000
`define OPT_TICK_CYCLES    (`OPT_MS_NS / `OPT_CLK_PERIOD_NS)
`define OPT_TICK_W         16

`endif

/* shared/opt_pkg.sv */
/*
 * Types shared by the output pulse timer bank.
 * Assumes opt_params.svh is on the include path.
 */
`include "opt_params.svh"

package opt_pkg;
	typedef logic [`OPT_SLOT_W-1:0]    opt_slot_t;
	typedef logic [`OPT_BASE_W-1:0]    opt_base_t;
	typedef logic [`OPT_MASK_W-1:0]    opt_mask_t;
	typedef logic [`OPT_DUR_W-1:0]     opt_dur_t;
	typedef logic [`OPT_NUM_LINES-1:0] opt_lines_t;
	typedef logic [`OPT_TICK_W-1:0]    opt_tick_t;
endpackage

/* sim/opt_cmd_proc.sv */
/*
 * Command processor model: APB master issuing timer requests.
 * Shares pclk with the bank; tasks are called from the bench.
 */
`timescale 1ns/1ps
`include "opt_params.svh"

module opt_cmd_proc
	import opt_pkg::*;
(
	// Clock and answers
	input wire logic         pclk,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic [31:0]  prdata,
	// Requests
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
	end

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines must not keep looking valid
		paddr <= ~a;
		pwdata <= ~wd;
	endtask

	task automatic timer_req(input opt_slot_t s, input opt_base_t b,
		input opt_mask_t m, input opt_dur_t d, input logic inv);
		logic [31:0] rd;
		logic e;
		xfer(1'b1, `OPT_ADDR_CMD, {15'h0, inv, 3'h0, b, 2'h0, s}, rd, e);
		xfer(1'b1, `OPT_ADDR_MASK, {16'h0, m}, rd, e);
		xfer(1'b1, `OPT_ADDR_DUR, {16'h0, d}, rd, e);
		xfer(1'b1, `OPT_ADDR_GO, 32'h1, rd, e);
	endtask
endmodule // opt_cmd_proc

/* sim/opt_timer_bank_props.sv */
/*
 * Port checker for the timer bank: APB timing and the start level.
 * Bound to every opt_timer_bank; expects a single-slave APB3 master.
 */
`timescale 1ns/1ps
`include "opt_params.svh"

module opt_timer_bank_props
	import opt_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 8
)
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Lines
	input wire opt_lines_t  out_lines
);
	logic [31:0] cmd_q;
	logic [31:0] mask_q;
	logic [31:0] dur_q;
	logic        wr_ok;
	opt_lines_t  sel;
	logic        go;

	assign wr_ok = psel && penable && pready && pwrite;
	// Mask bits past line 31 fall off the top of the shift
	assign sel = {16'h0, mask_q[15:0]} << cmd_q[12:8];
	assign go = wr_ok && paddr == `OPT_ADDR_GO && pwdata[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q <= '0;
			mask_q <= '0;
			dur_q <= '0;
		end else if (wr_ok) begin
			if (paddr == `OPT_ADDR_CMD) cmd_q <= pwdata;
			if (paddr == `OPT_ADDR_MASK) mask_q <= pwdata;
			if (paddr == `OPT_ADDR_DUR) dur_q <= pwdata;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
	a_wait: assert property (p_wait) else $error("wait state wrong");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready held");
	property p_sel; pready |-> psel && penable; endproperty
	a_sel: assert property (p_sel) else $error("pready outside access");
	property p_unmap;
		pready && paddr > `OPT_ADDR_ACT_HI |-> pslverr && (pwrite || prdata == '0);
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access");
	property p_map;
		pready && paddr <= `OPT_ADDR_ACT_HI && paddr[1:0] == 2'b00 |-> !pslverr;
	endproperty
	a_map: assert property (p_map) else $error("error on mapped");
	property p_go_rd;
		pready && !pwrite && paddr == `OPT_ADDR_GO |-> prdata == '0;
	endproperty
	a_go_rd: assert property (p_go_rd) else $error("launch reads nonzero");
	property p_lines;
		pready && !pwrite && paddr == `OPT_ADDR_LINES |-> prdata == $past(out_lines);
	endproperty
	a_lines: assert property (p_lines) else $error("line readback wrong");
	property p_start;
		go && dur_q[15:0] > 16'h1 |-> ##[2:3] (out_lines & sel) == (cmd_q[16] ? '0 : sel);
	endproperty
	a_start: assert property (p_start) else $error("start level wrong");

	c_go: cover property (go);
	c_inv: cover property (go && cmd_q[16]);
	c_err: cover property (pready && pslverr);
endmodule // opt_timer_bank_props

bind opt_timer_bank opt_timer_bank_props #(.TICK_CYCLES(TICK_CYCLES))
	opt_timer_bank_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.out_lines(out_lines));

/* sim/opt_timer_bank_tb_top.sv */
/*
 * Self-checking bench for the timer bank, driven through opt_cmd_proc.
 * Uses a 20-cycle millisecond so each run stays a few hundred cycles.
 */
`timescale 1ns/1ps
`include "opt_params.svh"

module opt_timer_bank_tb_top;
	localparam int TICK = 20;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, out_lines;
	int          error_cnt = 0;
	int          n_compared = 0;
	int          cyc = 0;

	always #12.5 pclk = ~pclk;

	opt_timer_bank #(.TICK_CYCLES(TICK)) opt_timer_bank_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .out_lines(out_lines));
	opt_cmd_proc opt_cmd_proc_inst (.pclk(pclk), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_err(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		opt_cmd_proc_inst.xfer(1'b0, a, 32'h0, rd, err);
		chk_word(rd, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		opt_cmd_proc_inst.xfer(1'b1, a, d, rd, err);
	endtask

	task automatic t_regs;
		rd_chk(`OPT_ADDR_LATCH, `OPT_LATCH_RST);
		rd_chk(`OPT_ADDR_ACT_HI, 32'h0);
		wr(`OPT_ADDR_LINES, 32'hffff_ffff);
		rd_chk(`OPT_ADDR_LINES, 32'h0);
		wr(`OPT_ADDR_LATCH, 32'h0000_3c00);
		rd_chk(`OPT_ADDR_LINES, 32'h0000_3c00);
		opt_cmd_proc_inst.xfer(1'b0, 8'h20, 32'h0, rd, err);
		chk_err(err, 1'b1);
		chk_word(rd, 32'h0);
		// An unmapped write must be refused and change nothing
		opt_cmd_proc_inst.xfer(1'b1, 8'h24, 32'hffff_ffff, rd, err);
		chk_err(err, 1'b1);
		rd_chk(`OPT_ADDR_LATCH, 32'h0000_3c00);
		// Staging readback keeps only the defined fields
		wr(`OPT_ADDR_CMD, 32'hffff_ffff);
		rd_chk(`OPT_ADDR_CMD, 32'h0001_1f3f);
		wr(`OPT_ADDR_MASK, 32'hffff_ffff);
		rd_chk(`OPT_ADDR_MASK, 32'h0000_ffff);
		wr(`OPT_ADDR_DUR, 32'hffff_ffff);
		rd_chk(`OPT_ADDR_DUR, 32'h0000_ffff);
		// A launch write with bit 0 clear must not start the staged slot
		wr(`OPT_ADDR_GO, 32'hffff_fffe);
		rd_chk(`OPT_ADDR_GO, 32'h0);
		rd_chk(`OPT_ADDR_ACT_HI, 32'h0);
		rd_chk(`OPT_ADDR_LINES, 32'h0000_3c00);
		$display("regs done");
	endtask

	task automatic t_inv;
		opt_cmd_proc_inst.timer_req(6'd63, 5'd10, 16'd13, 16'd2, 1'b1);
		rd_chk(`OPT_ADDR_LINES, 32'h0000_0800);
		rd_chk(`OPT_ADDR_ACT_HI, 32'h8000_0000);
		wr(`OPT_ADDR_LATCH, 32'h0);
		rd_chk(`OPT_ADDR_LINES, 32'h0);
		repeat (3 * TICK) @(posedge pclk);
		rd_chk(`OPT_ADDR_LINES, 32'h0000_3400);
		rd_chk(`OPT_ADDR_ACT_HI, 32'h0);
		$display("invert done");
	endtask

	task automatic t_wrap;
		opt_cmd_proc_inst.timer_req(6'd0, 5'd30, 16'hffff, 16'd2, 1'b0);
		repeat (3) @(negedge pclk);
		chk_word(out_lines, 32'hc000_3400);
		rd_chk(`OPT_ADDR_ACT_LO, 32'h1);
		repeat (3 * TICK) @(posedge pclk);
		rd_chk(`OPT_ADDR_LINES, 32'h0000_3400);
		$display("wrap done");
	endtask

	task automatic t_restart;
		opt_cmd_proc_inst.timer_req(6'd5, 5'd0, 16'd1, 16'd3, 1'b0);
		rd_chk(`OPT_ADDR_LINES, 32'h0000_3401);
		repeat (TICK) @(posedge pclk);
		opt_cmd_proc_inst.timer_req(6'd5, 5'd4, 16'd1, 16'd4, 1'b0);
		rd_chk(`OPT_ADDR_LINES, 32'h0000_3410);
		// Past the first count's end, inside the second's
		repeat (2 * TICK) @(posedge pclk);
		rd_chk(`OPT_ADDR_LINES, 32'h0000_3410);
		repeat (3 * TICK) @(posedge pclk);
		rd_chk(`OPT_ADDR_LINES, 32'h0000_3400);
		$display("restart done");
	endtask

	// Reset in mid-run drops running slots and the latch
	task automatic t_reset;
		opt_cmd_proc_inst.timer_req(6'd33, 5'd2, 16'h0003, 16'd5, 1'b0);
		rd_chk(`OPT_ADDR_LINES, 32'h0000_340c);
		rd_chk(`OPT_ADDR_ACT_HI, 32'h0000_0002);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk_word(out_lines, `OPT_LATCH_RST);
		presetn <= 1'b1;
		rd_chk(`OPT_ADDR_ACT_HI, 32'h0);
		rd_chk(`OPT_ADDR_LATCH, `OPT_LATCH_RST);
		rd_chk(`OPT_ADDR_LINES, `OPT_LATCH_RST);
		$display("reset done");
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_inv();
		t_wrap();
		t_restart();
		t_reset();
		stop_test();
	end
endmodule // opt_timer_bank_tb_top
